//--- core/gpx_cfg.svh
// register offsets, reset values and timing counts of the port block
`ifndef GPX_CFG_SVH
`define GPX_CFG_SVH
// ==========================================================================
// register offsets
`define GPX_A_P7_DATA 5'h00
`define GPX_A_P7_DIR 5'h01
`define GPX_A_P7_PULL 5'h02
`define GPX_A_P7_PIN 5'h03
`define GPX_A_P8_DATA 5'h04
`define GPX_A_P8_DIR 5'h05
`define GPX_A_P8_PIN 5'h06
`define GPX_A_P8_ANA 5'h07
`define GPX_A_PB_DATA 5'h08
`define GPX_A_PB_DIR 5'h09
`define GPX_A_PB_PULL 5'h0A
`define GPX_A_PB_PIN 5'h0B
`define GPX_A_PC_DATA 5'h0C
`define GPX_A_PC_DIR 5'h0D
`define GPX_A_PC_PULL 5'h0E
`define GPX_A_PC_PIN 5'h0F
`define GPX_A_PE_DATA 5'h10
`define GPX_A_PE_DIR 5'h11
`define GPX_A_PE_PULL 5'h12
`define GPX_A_PE_PIN 5'h13
`define GPX_A_PF_DATA 5'h14
`define GPX_A_PF_DIR 5'h15
`define GPX_A_PF_PULL 5'h16
`define GPX_A_PF_PIN 5'h17
`define GPX_A_TRIG 5'h18
`define GPX_A_IRQ_EN 5'h19
`define GPX_A_IRQ_STS 5'h1A
`define GPX_A_IRQ_CLR 5'h1B
`define GPX_A_P7_FUNC 5'h1C
// ==========================================================================
// field positions
`define GPX_F_WDT_SEL 0
// ==========================================================================
// reset values
`define GPX_RST_BYTE 8'h00
`define GPX_RST_NIB 4'h0
// ==========================================================================
// timing
`define GPX_CLK_NS 5
`define GPX_NF_NS 40
`define GPX_NF_CYC ((`GPX_NF_NS + `GPX_CLK_NS - 1) / `GPX_CLK_NS)
`endif

//--- core/gpx_pkg.sv
// types shared by the port block
package gpx_pkg;
  `include "gpx_cfg.svh"

  // ========================================================================
  // pad carriers
  typedef struct packed {
    logic [3:0] o;
    logic [3:0] oe;
    logic [3:0] pu;
  } gpx_pad4_t;

  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
    logic [7:0] pu;
  } gpx_pad8_t;

  typedef struct packed {
    logic own;
    logic [2:0] o;
    logic [2:0] oe;
  } gpx_dbg_t;

  // ========================================================================
  // trigger encodings
  typedef enum logic [1:0] {
    GPX_AB_RISE, GPX_AB_FALL, GPX_AB_HIGH, GPX_AB_LOW
  } gpx_trig_ab_t;

  typedef enum logic [1:0] {
    GPX_CD_RISE, GPX_CD_FALL, GPX_CD_BOTH, GPX_CD_BOTH2
  } gpx_trig_cd_t;

  // ========================================================================
  // block state
  typedef struct packed {
    logic [3:0] p7_do;
    logic [3:0] p7_dir;
    logic [3:0] p7_pu;
    logic p7_wdt;
    logic [7:0] p8_do;
    logic [7:0] p8_dir;
    logic [7:0] p8_ana;
    logic [7:0] pb_do;
    logic [7:0] pb_dir;
    logic [7:0] pb_pu;
    logic [7:0] pc_do;
    logic [7:0] pc_dir;
    logic [7:0] pc_pu;
    logic [7:0] pe_do;
    logic [3:0] pe_dir;
    logic [7:0] pe_pu;
    logic [7:0] pf_do;
    logic [3:0] pf_dir;
    logic [7:0] pf_pu;
    logic [7:0] trig;
    logic [3:0] ien;
    logic [3:0] sts;
    logic [3:0] prev;
    logic d_filt;
    logic [3:0] nf_cnt;
    logic t0_cap_lo;
    logic t0_cap_hi;
    logic t0_evt;
    logic [7:0] rdata;
  } gpx_state_t;
endpackage : gpx_pkg

//--- core/gpx_sync.sv
// three-stage pin synchroniser with agreement of the last two stages
module gpx_sync #(
  parameter int W = 44
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [W-1:0] pin_raw,
  output logic [W-1:0] pin_q
);
  import gpx_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } gpx_sync_st_t;

  gpx_sync_st_t st;
  gpx_sync_st_t next_st;
  logic [W-1:0] agree;

  // ========================================================================
  // per-bit agreement
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++)
    begin : g_bit
      assign agree[gi] = (st.s2[gi] == st.s3[gi]);
    end
  endgenerate

  always_comb
  begin
    next_st = st;
    next_st.s1 = pin_raw;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.q = (st.s3 & agree) | (st.q & ~agree);
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign pin_q = st.q;

  // ========================================================================
  // checks
  chk_sync_agree: assert property (@(posedge mclk) disable iff (!reset_n)
    ((st.q ^ $past(st.q)) & (st.q ^ $past(st.s3))) == '0)
    else $error("synchroniser output changed without agreement");
endmodule : gpx_sync

//--- core/gpx_top.sv
// port group logic: four- and eight-bit pads, external interrupts
// How it works
// [RULE_01] four-bit port, per-pin direction and pull-up
// [RULE_02] a/b edge or level, c/d edges
// [RULE_03] fourth interrupt input passes noise filter
// [RULE_04] first three interrupts release hold state
// [RULE_05] pins route to timer capture and event
// [RULE_06] pin zero can drive watchdog output
// [RULE_07] open-drain eight-bit port shared with converter
// [RULE_08] two per-bit ports, debugger on top three
// [RULE_09] two ports with direction per pin pair
// [RULE_10] pull-ups switch per pin independently
// [RULE_11] reset: inputs, no pull-ups, detection off
//
// Implementation choices: strobed register access and the address map.
module gpx_top (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [4:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic [3:0] p7_in,
  output gpx_pkg::gpx_pad4_t p7_pad,
  input wire logic [7:0] p8_in,
  output gpx_pkg::gpx_pad8_t p8_pad,
  input wire logic [7:0] pb_in,
  output gpx_pkg::gpx_pad8_t pb_pad,
  input wire logic [7:0] pc_in,
  output gpx_pkg::gpx_pad8_t pc_pad,
  input wire logic [7:0] pe_in,
  output gpx_pkg::gpx_pad8_t pe_pad,
  input wire logic [7:0] pf_in,
  output gpx_pkg::gpx_pad8_t pf_pad,
  input wire gpx_pkg::gpx_dbg_t dbg_drv,
  output logic debugger_pin_a,
  output logic debugger_pin_b,
  output logic debugger_pin_c,
  input wire logic wdt_out,
  output logic t0_cap_lo,
  output logic t0_cap_hi,
  output logic t0_evt,
  output logic ext_irq_a,
  output logic ext_irq_b,
  output logic ext_irq_c,
  output logic ext_irq_d,
  output logic hold_wake,
  output logic irq
);
  import gpx_pkg::*;

  gpx_state_t st;
  gpx_state_t next_st;
  logic [43:0] q;
  logic [3:0] p7_q;
  logic [7:0] p8_q;
  logic [7:0] pb_q;
  logic [7:0] pc_q;
  logic [7:0] pe_q;
  logic [7:0] pf_q;
  logic [3:0] cur;
  logic [3:0] rise;
  logic [3:0] fall;
  logic [3:0] ev;
  logic [3:0] clr;
  logic [7:0] pe_dir8;
  logic [7:0] pf_dir8;
  logic p70_val;

  // ==========================================================================
  // pin synchronisers
  gpx_sync #(
    .W(44)
  ) u_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .pin_raw({pf_in, pe_in, pc_in, pb_in, p8_in, p7_in}),
    .pin_q(q)
  );

  assign p7_q = q[3:0];
  assign p8_q = q[11:4] & ~st.p8_ana; // RULE_07
  assign pb_q = q[19:12];
  assign pc_q = q[27:20];
  assign pe_q = q[35:28];
  assign pf_q = q[43:36];

  // ==========================================================================
  // interrupt edge sources
  assign cur = {st.d_filt, p7_q[2:0]}; // RULE_03
  assign rise = cur & ~st.prev;
  assign fall = ~cur & st.prev;

  // ==========================================================================
  // pair-wise direction expansion
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_pair
      assign pe_dir8[gi] = st.pe_dir[gi/2]; // RULE_09
      assign pf_dir8[gi] = st.pf_dir[gi/2]; // RULE_09
    end
  endgenerate

  // ==========================================================================
  // next state
  always_comb
  begin
    next_st = st;
    ev = 4'h0;
    clr = 4'h0;
    next_st.rdata = 8'h00;
    if (wr)
    begin
      case (addr)
        `GPX_A_P7_DATA: next_st.p7_do = wdata[3:0];
        `GPX_A_P7_DIR: next_st.p7_dir = wdata[3:0]; // RULE_01
        `GPX_A_P7_PULL: next_st.p7_pu = wdata[3:0]; // RULE_10
        `GPX_A_P7_FUNC: next_st.p7_wdt = wdata[`GPX_F_WDT_SEL]; // RULE_06
        `GPX_A_P8_DATA: next_st.p8_do = wdata;
        `GPX_A_P8_DIR: next_st.p8_dir = wdata; // RULE_07
        `GPX_A_P8_ANA: next_st.p8_ana = wdata;
        `GPX_A_PB_DATA: next_st.pb_do = wdata;
        `GPX_A_PB_DIR: next_st.pb_dir = wdata; // RULE_08
        `GPX_A_PB_PULL: next_st.pb_pu = wdata; // RULE_10
        `GPX_A_PC_DATA: next_st.pc_do = wdata;
        `GPX_A_PC_DIR: next_st.pc_dir = wdata; // RULE_08
        `GPX_A_PC_PULL: next_st.pc_pu = wdata; // RULE_10
        `GPX_A_PE_DATA: next_st.pe_do = wdata;
        `GPX_A_PE_DIR: next_st.pe_dir = wdata[3:0]; // RULE_09
        `GPX_A_PE_PULL: next_st.pe_pu = wdata; // RULE_10
        `GPX_A_PF_DATA: next_st.pf_do = wdata;
        `GPX_A_PF_DIR: next_st.pf_dir = wdata[3:0]; // RULE_09
        `GPX_A_PF_PULL: next_st.pf_pu = wdata; // RULE_10
        `GPX_A_TRIG: next_st.trig = wdata;
        `GPX_A_IRQ_EN: next_st.ien = wdata[3:0];
        `GPX_A_IRQ_CLR: clr = wdata[3:0];
        default: ;
      endcase
    end
    if (rd)
    begin
      case (addr)
        `GPX_A_P7_DATA: next_st.rdata = {4'h0, st.p7_do};
        `GPX_A_P7_DIR: next_st.rdata = {4'h0, st.p7_dir};
        `GPX_A_P7_PULL: next_st.rdata = {4'h0, st.p7_pu};
        `GPX_A_P7_PIN: next_st.rdata = {4'h0, p7_q};
        `GPX_A_P7_FUNC: next_st.rdata = {7'h00, st.p7_wdt};
        `GPX_A_P8_DATA: next_st.rdata = st.p8_do;
        `GPX_A_P8_DIR: next_st.rdata = st.p8_dir;
        `GPX_A_P8_PIN: next_st.rdata = p8_q;
        `GPX_A_P8_ANA: next_st.rdata = st.p8_ana;
        `GPX_A_PB_DATA: next_st.rdata = st.pb_do;
        `GPX_A_PB_DIR: next_st.rdata = st.pb_dir;
        `GPX_A_PB_PULL: next_st.rdata = st.pb_pu;
        `GPX_A_PB_PIN: next_st.rdata = pb_q;
        `GPX_A_PC_DATA: next_st.rdata = st.pc_do;
        `GPX_A_PC_DIR: next_st.rdata = st.pc_dir;
        `GPX_A_PC_PULL: next_st.rdata = st.pc_pu;
        `GPX_A_PC_PIN: next_st.rdata = pc_q;
        `GPX_A_PE_DATA: next_st.rdata = st.pe_do;
        `GPX_A_PE_DIR: next_st.rdata = {4'h0, st.pe_dir};
        `GPX_A_PE_PULL: next_st.rdata = st.pe_pu;
        `GPX_A_PE_PIN: next_st.rdata = pe_q;
        `GPX_A_PF_DATA: next_st.rdata = st.pf_do;
        `GPX_A_PF_DIR: next_st.rdata = {4'h0, st.pf_dir};
        `GPX_A_PF_PULL: next_st.rdata = st.pf_pu;
        `GPX_A_PF_PIN: next_st.rdata = pf_q;
        `GPX_A_TRIG: next_st.rdata = st.trig;
        `GPX_A_IRQ_EN: next_st.rdata = {4'h0, st.ien};
        `GPX_A_IRQ_STS: next_st.rdata = {4'h0, st.sts};
        default: next_st.rdata = 8'h00;
      endcase
    end
    // noise filter: a change must persist for the full count
    if (p7_q[3] != st.d_filt)
    begin
      if (st.nf_cnt == 4'(`GPX_NF_CYC - 1))
      begin
        next_st.d_filt = p7_q[3]; // RULE_03
        next_st.nf_cnt = 4'h0;
      end
      else
        next_st.nf_cnt = st.nf_cnt + 4'h1;
    end
    else
      next_st.nf_cnt = 4'h0;
    // trigger selection
    for (int i = 0; i < 2; i++)
    begin
      unique case (gpx_trig_ab_t'(st.trig[2*i +: 2]))
        GPX_AB_RISE: ev[i] = rise[i]; // RULE_02
        GPX_AB_FALL: ev[i] = fall[i]; // RULE_02
        GPX_AB_HIGH: ev[i] = cur[i]; // RULE_02
        GPX_AB_LOW: ev[i] = ~cur[i]; // RULE_02
      endcase
    end
    for (int i = 2; i < 4; i++)
    begin
      unique case (gpx_trig_cd_t'(st.trig[2*i +: 2]))
        GPX_CD_RISE: ev[i] = rise[i]; // RULE_02
        GPX_CD_FALL: ev[i] = fall[i]; // RULE_02
        GPX_CD_BOTH, GPX_CD_BOTH2: ev[i] = rise[i] | fall[i]; // RULE_02
      endcase
    end
    ev = ev & st.ien; // RULE_11
    next_st.sts = (st.sts & ~clr) | ev;
    next_st.prev = cur;
    next_st.t0_cap_lo = p7_q[0] | p7_q[2]; // RULE_05
    next_st.t0_cap_hi = p7_q[1] | p7_q[3]; // RULE_05
    next_st.t0_evt = p7_q[2] | p7_q[3]; // RULE_05
  end

  // ==========================================================================
  // state register
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      st <= '0; // RULE_11
    else
      st <= next_st;
  end

  // ==========================================================================
  // pad drive
  assign p70_val = st.p7_wdt ? wdt_out : st.p7_do[0]; // RULE_06
  assign p7_pad.o = {st.p7_do[3:1], 1'b0};
  assign p7_pad.oe = {st.p7_dir[3:1], st.p7_dir[0] & ~p70_val}; // RULE_01
  assign p7_pad.pu = st.p7_pu; // RULE_10
  assign p8_pad.o = 8'h00;
  assign p8_pad.oe = st.p8_dir & ~st.p8_do & ~st.p8_ana; // RULE_07
  assign p8_pad.pu = 8'h00;
  assign pb_pad.o = st.pb_do;
  assign pb_pad.oe = st.pb_dir; // RULE_08
  assign pb_pad.pu = st.pb_pu;
  assign pc_pad.o = dbg_drv.own ? {dbg_drv.o, st.pc_do[4:0]} : st.pc_do;
  assign pc_pad.oe = dbg_drv.own ? {dbg_drv.oe, st.pc_dir[4:0]}
                                 : st.pc_dir; // RULE_08
  assign pc_pad.pu = st.pc_pu;
  assign pe_pad.o = st.pe_do;
  assign pe_pad.oe = pe_dir8;
  assign pe_pad.pu = st.pe_pu;
  assign pf_pad.o = st.pf_do;
  assign pf_pad.oe = pf_dir8;
  assign pf_pad.pu = st.pf_pu;
  assign debugger_pin_a = pc_q[5]; // RULE_08
  assign debugger_pin_b = pc_q[6];
  assign debugger_pin_c = pc_q[7];

  // ==========================================================================
  // outputs
  assign rdata = st.rdata;
  assign t0_cap_lo = st.t0_cap_lo;
  assign t0_cap_hi = st.t0_cap_hi;
  assign t0_evt = st.t0_evt;
  assign ext_irq_a = st.sts[0];
  assign ext_irq_b = st.sts[1];
  assign ext_irq_c = st.sts[2];
  assign ext_irq_d = st.sts[3];
  assign hold_wake = |(st.sts[2:0] & st.ien[2:0]); // RULE_04
  assign irq = |(st.sts & st.ien);

  // ==========================================================================
  // checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  chk_pull_write: assert property ( // RULE_01
    wr && addr == `GPX_A_P7_PULL |=> p7_pad.pu == $past(wdata[3:0]))
    else $error("port seven pull-up not written");

  chk_level_high: assert property ( // RULE_02
    st.ien[0] && st.trig[1:0] == 2'h2 && p7_q[0] |=> st.sts[0])
    else $error("high level trigger missed");

  chk_filter_time: assert property ( // RULE_03
    $changed(st.d_filt) |-> $past(st.nf_cnt) == 4'(`GPX_NF_CYC - 1))
    else $error("filtered input changed too soon");

  chk_wake_src: assert property ( // RULE_04
    $rose(st.sts[2]) && st.ien[2] |-> hold_wake)
    else $error("hold release missing");

  chk_wake_d: assert property ( // RULE_04
    st.sts[2:0] == 3'h0 |-> !hold_wake)
    else $error("fourth input released hold");

  chk_cap_route: assert property ( // RULE_05
    p7_q[1] |=> t0_cap_hi)
    else $error("capture route lost");

  chk_wdt_drive: assert property ( // RULE_06
    st.p7_wdt && st.p7_dir[0] && !wdt_out |-> p7_pad.oe[0])
    else $error("watchdog drive missing");

  chk_open_drain: assert property ( // RULE_07
    (p8_pad.oe & ~st.p8_dir) == 8'h00 && p8_pad.o == 8'h00)
    else $error("open drain port drives high");

  chk_pair_dir: assert property ( // RULE_09
    (pe_pad.oe & 8'h55) == ((pe_pad.oe >> 1) & 8'h55))
    else $error("pin pair direction split");

  chk_clear_sts: assert property ( // RULE_11
    wr && addr == `GPX_A_IRQ_CLR && wdata[0] && !ev[0] |=> !st.sts[0])
    else $error("status bit not cleared");

  cov_irq_a: cover property ($rose(st.sts[0]));
  cov_irq_d: cover property ($rose(st.sts[3]));
  cov_wake: cover property ($rose(hold_wake));
endmodule : gpx_top

//--- test/gpx_board.sv
// board-side model: drives, pulls or leaves floating the pins of one port
module gpx_board (
  input wire logic mclk,
  input wire gpx_pkg::gpx_pad8_t pad,
  input wire logic [7:0] ext,
  input wire logic [7:0] ext_en,
  output logic [7:0] pin
);
  timeunit 1ns;
  timeprecision 1ps;
  import gpx_pkg::*;
  // ==========================================================================
  // wire level
  logic [7:0] idle = 8'h5A;

  // a floating pin wanders every cycle so no stale level can pass
  always @(posedge mclk)
    idle <= ~idle;

  // a driving pad wins over the board; open-drain pads only ever drive low
  assign pin = (pad.oe & pad.o) | (~pad.oe & ext_en & ext)
    | (~pad.oe & ~ext_en & pad.pu)
    | (~pad.oe & ~ext_en & ~pad.pu & idle);
endmodule : gpx_board

//--- test/gpx_top_test.sv
// self-checking bench for the port group
`include "gpx_cfg.svh"
module gpx_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import gpx_pkg::*;
  // ==========================================================================
  // signals
  logic mclk;
  logic reset_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic wdt_out = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [7:0] ext [6] = '{default: 8'h00};
  logic [7:0] pin [6];
  gpx_pad8_t pad [6];
  gpx_pad4_t p7_pad;
  gpx_dbg_t dbg_drv = '0;
  logic t0_cap_lo;
  logic t0_cap_hi;
  logic t0_evt;
  logic irq;
  logic hold_wake;
  logic [3:0] xirq;
  logic [2:0] dbgp;
  logic [7:0] sh [32];
  logic [7:0] rs;
  logic [3:0] lv;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;

  gpx_top dut (
    .mclk(mclk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata),
    .p7_in(pin[0][3:0]), .p7_pad(p7_pad), .p8_in(pin[1]), .p8_pad(pad[1]),
    .pb_in(pin[2]), .pb_pad(pad[2]), .pc_in(pin[3]), .pc_pad(pad[3]),
    .pe_in(pin[4]), .pe_pad(pad[4]), .pf_in(pin[5]), .pf_pad(pad[5]),
    .dbg_drv(dbg_drv), .debugger_pin_a(dbgp[0]),
    .debugger_pin_b(dbgp[1]), .debugger_pin_c(dbgp[2]),
    .wdt_out(wdt_out), .t0_cap_lo(t0_cap_lo), .t0_cap_hi(t0_cap_hi),
    .t0_evt(t0_evt), .ext_irq_a(xirq[0]), .ext_irq_b(xirq[1]),
    .ext_irq_c(xirq[2]), .ext_irq_d(xirq[3]),
    .hold_wake(hold_wake), .irq(irq)
  );

  assign pad[0] = '{o: {4'h0, p7_pad.o}, oe: {4'h0, p7_pad.oe},
    pu: {4'h0, p7_pad.pu}};

  for (genvar g = 0; g < 6; g++)
  begin : g_board
    gpx_board board (
      .mclk(mclk), .pad(pad[g]), .ext(ext[g]), .ext_en(8'hFF), .pin(pin[g])
    );
  end

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      failures++;
      conclude();
    end
  end
  // ==========================================================================
  // helpers
  task conclude;
    if (failures == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task wreg(input logic [4:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    sh[a] = d;
  endtask : wreg

  task rreg(input logic [4:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rreg

  task rchk(input logic [4:0] a, input logic [7:0] e);
    rreg(a, rs);
    chk(rs, e);
  endtask : rchk

  function automatic logic [7:0] rw_mask(logic [4:0] a);
    case (a)
      5'h00, 5'h01, 5'h02, 5'h11, 5'h15, 5'h19: return 8'h0F;
      5'h1C: return 8'h01;
      5'h03, 5'h06, 5'h0B, 5'h0F, 5'h13, 5'h17, 5'h1A, 5'h1B, 5'h1D,
      5'h1E, 5'h1F: return 8'h00;
      default: return 8'hFF;
    endcase
  endfunction : rw_mask

  function automatic logic [7:0] pair(logic [3:0] d);
    for (int k = 0; k < 8; k++)
      pair[k] = d[k / 2];
  endfunction : pair

  function automatic logic irq_exp(int x, int code, int ph);
    if (ph == 0)
      return x < 2 && code == 3;
    return code == ph - 1 || code >= 2;
  endfunction : irq_exp

  task do_reset;
    reset_n <= 1'b0;
    wdt_out <= 1'b0;
    dbg_drv <= '0;
    foreach (ext[k])
      ext[k] <= 8'h00;
    foreach (sh[k])
      sh[k] = 8'h00;
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
  endtask : do_reset

  task chk_pads;
    logic [3:0] d;
    logic [7:0] e;
    d = sh[5'h01][3:0];
    e = {4'h0, d[3:1], d[0] & ~(sh[5'h1C][0] ? wdt_out : sh[5'h00][0])};
    chk({4'h0, p7_pad.oe}, e);
    chk({4'h0, p7_pad.pu}, sh[5'h02] & 8'h0F);
    e = {4'h0, sh[5'h00][3:1] & d[3:1], 1'b0};
    chk({4'h0, p7_pad.o & {d[3:1], 1'b1}}, e);
    chk(pad[1].oe, sh[5'h05] & ~sh[5'h04] & ~sh[5'h07]);
    chk(pad[1].o & pad[1].oe | pad[1].pu, 8'h00);
    for (int k = 2; k < 6; k++)
    begin
      e = (k < 4) ? sh[4 * k + 1] : pair(sh[4 * k + 1][3:0]);
      chk(pad[k].oe, e);
      chk(pad[k].pu, sh[4 * k + 2]);
      chk(pad[k].o & e, sh[4 * k] & e);
    end
  endtask : chk_pads

  task reset_scan;
    for (int a = 0; a < 32; a++)
      rchk(5'(a), 8'h00);
    chk_pads();
    chk({4'h0, t0_evt, t0_cap_hi, t0_cap_lo, irq | hold_wake}, 8'h00);
  endtask : reset_scan

  task irq_case(input int x, input int code, input logic en);
    logic e;
    wreg(`GPX_A_IRQ_EN, 8'(en) << x);
    wreg(`GPX_A_TRIG, 8'(code) << (2 * x));
    for (int ph = 0; ph < 3; ph++)
    begin
      wreg(`GPX_A_IRQ_CLR, 8'h0F);
      ext[0][x] <= (ph == 1);
      repeat (20) @(posedge mclk);
      e = en & irq_exp(x, code, ph);
      rchk(`GPX_A_IRQ_STS, 8'(e) << x);
      chk({xirq, 2'b00, irq, hold_wake}, {4'(e) << x, 2'b00, e, e & (x < 3)});
    end
  endtask : irq_case
  // ==========================================================================
  // scenarios
  initial
  begin
    void'($urandom(43));
    do_reset();
    reset_scan();
    for (int r = 0; r < 4; r++)
    begin
      wdt_out <= 1'($urandom);
      for (int a = 0; a < 32; a++)
        if (rw_mask(5'(a)) != 8'h00)
          wreg(5'(a), 8'($urandom));
      repeat (2) @(posedge mclk);
      chk_pads();
      for (int a = 0; a < 32; a++)
        if (rw_mask(5'(a)) != 8'h00)
          rchk(5'(a), sh[a] & rw_mask(5'(a)));
      foreach (ext[k])
        ext[k] <= 8'($urandom);
      repeat (8) @(posedge mclk);
      rchk(`GPX_A_P7_PIN, pin[0] & 8'h0F);
      rchk(`GPX_A_P8_PIN, pin[1] & ~sh[5'h07]);
      for (int k = 2; k < 6; k++)
        rchk(5'(4 * k + 3), pin[k]);
    end
    wdt_out <= 1'b0;
    wreg(`GPX_A_P7_FUNC, 8'h01);
    wreg(`GPX_A_P7_DIR, 8'h01);
    #1 chk({4'h0, p7_pad.oe}, 8'h01);
    @(posedge mclk);
    wdt_out <= 1'b1;
    @(posedge mclk);
    #1 chk({4'h0, p7_pad.oe}, 8'h00);
    wreg(`GPX_A_P7_DIR, 8'h00);
    wreg(`GPX_A_P7_FUNC, 8'h00);
    ext[0] <= 8'h00;
    for (int x = 0; x < 4; x++)
      for (int c = 0; c < 4; c++)
        irq_case(x, c, 1'b1);
    irq_case(0, 0, 1'b0);
    irq_case(3, 2, 1'b0);
    for (int x = 2; x < 4; x++)
    begin
      wreg(`GPX_A_IRQ_EN, 8'h01 << x);
      wreg(`GPX_A_TRIG, 8'h00);
      wreg(`GPX_A_IRQ_CLR, 8'h0F);
      ext[0][x] <= 1'b1;
      repeat (7) @(posedge mclk);
      ext[0][x] <= 1'b0;
      repeat (20) @(posedge mclk);
      rchk(`GPX_A_IRQ_STS, 8'(x == 2) << x);
    end
    for (int v = 0; v < 16; v++)
    begin
      lv = 4'(v);
      ext[0] <= 8'(v);
      repeat (8) @(posedge mclk);
      #1 rs = {5'h00, lv[2] | lv[3], lv[1] | lv[3], lv[0] | lv[2]};
      chk({5'h00, t0_evt, t0_cap_hi, t0_cap_lo}, rs);
    end
    for (int r = 0; r < 3; r++)
    begin
      wreg(`GPX_A_PC_DIR, 8'($urandom));
      dbg_drv <= {1'b1, 6'($urandom)};
      ext[3] <= 8'($urandom);
      repeat (8) @(posedge mclk);
      #1 rs = {2'b00, dbg_drv.oe, dbg_drv.o & dbg_drv.oe};
      chk({2'b00, pad[3].oe[7:5], pad[3].o[7:5] & dbg_drv.oe}, rs);
      chk({5'h00, dbgp}, {5'h00, pin[3][7:5]});
    end
    do_reset();
    reset_scan();
    conclude();
  end
endmodule : gpx_top_test
